/* File: rtl/i2cr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cr_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } i2cr_fifo_type;

  i2cr_fifo_type r;
  i2cr_fifo_type next_r;
  logic          push;
  logic          pop;

  assign inReady  = (r.cnt != (PW+1)'(DEPTH));
  assign outValid = (r.cnt != '0);
  assign outData  = r.mem[r.rp];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = inData;
      next_r.wp        = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + PW'(1);
    end
    if (pop) begin
      next_r.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + PW'(1);
    end
    next_r.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

module i2cr_host
  import i2cr_pkg::*;
#(
  parameter int QCYC  = SCL_QUARTER_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Serial link
  i2cr_if.host            link,
  // Command
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire logic       cmdRead,
  input  wire logic [6:0] cmdAddr,
  input  wire logic [7:0] cmdReg,
  input  wire logic [7:0] cmdLen,
  // Write data
  input  wire logic       wdValid,
  output logic            wdReady,
  input  wire logic [7:0] wdData,
  // Results
  output logic            rdValid,
  output logic      [7:0] rdData,
  output logic            done,
  output logic            nack
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    i2cr_hstate_type st;
    i2cr_stage_type  stg;
    logic [1:0]      q;
    logic [15:0]     cnt;
    logic [2:0]      bitCnt;
    logic [7:0]      shift;
    logic            sclLow;
    logic            sdaLow;
    logic            sdaA;
    logic            sdaB;
    logic            ackBit;
    logic            rd;
    logic [6:0]      addr;
    logic [7:0]      regNum;
    logic [7:0]      left;
    logic            rdValid;
    logic [7:0]      rdData;
    logic            done;
    logic            nack;
  } i2cr_host_type;

  localparam i2cr_host_type RST_STATE = '{st: HS_IDLE, stg: SG_ADDRW, default: '0};

  i2cr_host_type r;
  i2cr_host_type next_r;
  logic          tick;
  logic          needByte;
  logic          fifoValid;
  logic [7:0]    fifoData;
  logic          pop;

  // Bytes wait here; an empty FIFO stretches the high half of the acknowledge clock
  i2cr_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (wdValid),
    .inReady  (wdReady),
    .inData   (wdData),
    .outValid (fifoValid),
    .outReady (pop),
    .outData  (fifoData)
  );

  assign tick     = (r.cnt == 16'(QCYC - 1));
  assign needByte = (r.st == HS_ACK) && (r.q == 2'h3) && (r.left != 8'h00) &&
                    ((r.stg == SG_REG && !r.rd) || r.stg == SG_WDATA);
  assign pop      = tick & needByte & fifoValid & ~r.ackBit;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r         = r;
    next_r.rdValid = 1'b0;
    next_r.done    = 1'b0;
    next_r.sdaA    = link.sda;
    next_r.sdaB    = r.sdaA;
    if (r.st == HS_IDLE) begin
      next_r.cnt = 16'h0000;
      next_r.q   = 2'h0;
      if (cmdValid) begin
        next_r.st     = HS_START;
        next_r.stg    = SG_ADDRW;
        next_r.rd     = cmdRead;
        next_r.addr   = cmdAddr;
        next_r.regNum = cmdReg;
        next_r.left   = cmdLen;
        next_r.nack   = 1'b0;
      end
    end else if (!tick) begin
      next_r.cnt = r.cnt + 16'h0001;
    end else if (!(needByte && !fifoValid && !r.ackBit)) begin
      next_r.cnt = 16'h0000;
      next_r.q   = r.q + 2'h1;
      case (r.st)
        HS_START: begin
          case (r.q)
            2'h0: next_r.sdaLow = 1'b0;
            2'h1: next_r.sclLow = 1'b0;
            2'h2: next_r.sdaLow = 1'b1;
            default: begin
              next_r.sclLow = 1'b1;
              next_r.st     = HS_BYTE;
              next_r.bitCnt = 3'h0;
              next_r.shift  = {r.addr, (r.stg == SG_ADDRR) ? RW_READ : RW_WRITE};
            end
          endcase
        end
        HS_BYTE: begin
          case (r.q)
            2'h0: next_r.sdaLow = (r.stg != SG_RDATA) & ~r.shift[7];
            2'h1: next_r.sclLow = 1'b0;
            2'h2: next_r.shift  = {r.shift[6:0], r.sdaB};
            default: begin
              next_r.sclLow = 1'b1;
              next_r.bitCnt = r.bitCnt + 3'h1;
              if (r.bitCnt == 3'(BYTE_BITS - 1)) begin
                next_r.st = HS_ACK;
              end
            end
          endcase
        end
        HS_ACK: begin
          case (r.q)
            2'h0: next_r.sdaLow = (r.stg == SG_RDATA) && (r.left != 8'h01);
            2'h1: next_r.sclLow = 1'b0;
            2'h2: next_r.ackBit = r.sdaB;
            default: begin
              next_r.sclLow = 1'b1;
              next_r.st     = HS_BYTE;
              next_r.bitCnt = 3'h0;
              next_r.ackBit = 1'b0;
              if (r.stg != SG_RDATA && r.ackBit) begin
                next_r.nack = 1'b1;
                next_r.st   = HS_STOP;
              end else if (r.stg == SG_ADDRW) begin
                next_r.stg   = SG_REG;
                next_r.shift = r.regNum;
              end else if (r.stg == SG_ADDRR) begin
                next_r.stg = SG_RDATA;
              end else if (r.stg == SG_RDATA) begin
                next_r.rdValid = 1'b1;
                next_r.rdData  = r.shift;
                next_r.left    = r.left - 8'h01;
                if (r.left == 8'h01) begin
                  next_r.st = HS_STOP;
                end
              end else if (r.rd) begin
                next_r.stg = SG_ADDRR;
                next_r.st  = HS_START;
              end else if (r.left == 8'h00) begin
                next_r.st = HS_STOP;
              end else begin
                next_r.stg   = SG_WDATA;
                next_r.shift = fifoData;
                next_r.left  = r.left - 8'h01;
              end
            end
          endcase
        end
        default: begin
          case (r.q)
            2'h0: next_r.sdaLow = 1'b1;
            2'h1: next_r.sclLow = 1'b0;
            2'h2: next_r.sdaLow = 1'b0;
            default: begin
              next_r.st   = HS_IDLE;
              next_r.done = 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= RST_STATE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.hostSclOut = 1'b0;
  assign link.hostSclOe  = ~r.sclLow;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe  = ~r.sdaLow;
  assign cmdReady        = (r.st == HS_IDLE);
  assign rdValid         = r.rdValid;
  assign rdData          = r.rdData;
  assign done            = r.done;
  assign nack            = r.nack;

endmodule
`default_nettype wire

/* File: include/i2cr_pkg.sv */
`default_nettype none
package i2cr_pkg;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR  = 7'h5A;
  localparam logic       RW_WRITE  = 1'h0;
  localparam logic       RW_READ   = 1'h1;
  localparam int         BYTE_BITS = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SCL_QUARTER_NS  = 2500;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int REG_COUNT  = 32;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01,
    DS_RX   = 5'h02,
    DS_ACK  = 5'h04,
    DS_TX   = 5'h08,
    DS_MACK = 5'h10
  } i2cr_dstate_type;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_REG  = 2'h1,
    PH_DATA = 2'h2
  } i2cr_phase_type;

  typedef enum logic [4:0] {
    HS_IDLE  = 5'h01,
    HS_START = 5'h02,
    HS_BYTE  = 5'h04,
    HS_ACK   = 5'h08,
    HS_STOP  = 5'h10
  } i2cr_hstate_type;

  typedef enum logic [2:0] {
    SG_ADDRW = 3'h0,
    SG_REG   = 3'h1,
    SG_WDATA = 3'h2,
    SG_ADDRR = 3'h3,
    SG_RDATA = 3'h4
  } i2cr_stage_type;

endpackage
`default_nettype wire

/* File: include/i2cr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface i2cr_if;
  logic      hostSclOut;
  logic      hostSclOe;
  logic      hostSdaOut;
  logic      hostSdaOe;
  logic      devSdaOut;
  logic      devSdaOe;
  wire logic scl;
  wire logic sda;

  // Wired-AND: an enable low pulls the line to its (low) output level
  assign scl = hostSclOe | hostSclOut;
  assign sda = (hostSdaOe | hostSdaOut) & (devSdaOe | devSdaOut);

  modport dev (input scl, input sda, output devSdaOut, output devSdaOe);
  modport host (input scl, input sda, output hostSclOut, output hostSclOe,
                output hostSdaOut, output hostSdaOe);
endinterface
`default_nettype wire

/* File: rtl/i2cr_device.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Bytes are eight bits, MSB first
// - Receiver acknowledges every byte in ninth bit
// - SDA fall/rise with SCL high: start/stop
// - Data changes only while SCL low
// - Answer only bus address 0x5A
// - Master sends 0xB4 write, 0xB5 read
// - Acknowledge holds SDA low whole clock
// - No limit on bytes per transfer
// - Master ends transfer with stop
// - All registers single and multi-byte accessible
// - Reads return successive registers while acknowledged
// - Writes: pointer byte, then successive registers
// - Write direction bit zero, then acknowledge
// - Acknowledge the register pointer byte
// - Acknowledge every written data byte
// - Read: write pointer, repeated start, read
// - After read address, drive addressed register
// - Master ends read with NACK, stop
// - Master acknowledges all but final byte
// - Lines only pulled low, else released
module i2cr_device
  import i2cr_pkg::*;
#(
  parameter int REGS = REG_COUNT,
  parameter int AW   = $clog2(REGS)
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Serial link
  i2cr_if.dev                      link,
  // Local register load
  input  wire logic                loadValid,
  input  wire logic [AW-1:0]       loadAddr,
  input  wire logic [7:0]          loadData,
  // Register file and write report
  output logic      [REGS*8-1:0]   regFlat,
  output logic                     wrValid,
  output logic      [AW-1:0]       wrAddr,
  output logic      [7:0]          wrData,
  output logic                     busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    i2cr_dstate_type          st;
    i2cr_phase_type           ph;
    logic                     sclA;
    logic                     sclB;
    logic                     sclC;
    logic                     sdaA;
    logic                     sdaB;
    logic                     sdaC;
    logic [3:0]               bitCnt;
    logic [7:0]               shift;
    logic [7:0]               ptr;
    logic                     rw;
    logic                     mAck;
    logic                     sdaLow;
    logic [REGS-1:0][7:0]     regs;
    logic                     wrValid;
    logic [AW-1:0]            wrAddr;
    logic [7:0]               wrData;
  } i2cr_dev_type;

  // Line stages start at the idle (high) level, so no false edge follows reset
  localparam i2cr_dev_type RST_STATE = '{st: DS_IDLE, ph: PH_ADDR, sclA: 1'b1, sclB: 1'b1,
                                         sclC: 1'b1, sdaA: 1'b1, sdaB: 1'b1, sdaC: 1'b1,
                                         default: '0};

  i2cr_dev_type r;
  i2cr_dev_type next_r;
  logic         sclRise;
  logic         sclFall;
  logic         startSeen;
  logic         stopSeen;
  logic         loadTx;

  // ----------------------------------------------------------------
  // Line events
  // ----------------------------------------------------------------
  // Edges look only at the second and third stages, never the first
  assign sclRise   = r.sclB & ~r.sclC;
  assign sclFall   = ~r.sclB & r.sclC;
  assign startSeen = r.sclB & r.sclC & r.sdaC & ~r.sdaB;
  assign stopSeen  = r.sclB & r.sclC & ~r.sdaC & r.sdaB;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r         = r;
    loadTx         = 1'b0;
    next_r.wrValid = 1'b0;
    next_r.sclA    = link.scl;
    next_r.sclB    = r.sclA;
    next_r.sclC    = r.sclB;
    next_r.sdaA    = link.sda;
    next_r.sdaB    = r.sdaA;
    next_r.sdaC    = r.sdaB;
    // A bus write later in this process overrides a load to the same register
    if (loadValid) begin
      next_r.regs[loadAddr] = loadData;
    end
    if (stopSeen) begin
      next_r.st     = DS_IDLE;
      next_r.sdaLow = 1'b0;
    end else if (startSeen) begin
      // Repeated start keeps ptr for the read phase
      next_r.st     = DS_RX;
      next_r.ph     = PH_ADDR;
      next_r.bitCnt = 4'h0;
      next_r.sdaLow = 1'b0;
    end else begin
      case (r.st)
        DS_RX: begin
          if (sclRise) begin
            next_r.shift  = {r.shift[6:0], r.sdaB};
            next_r.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == 4'(BYTE_BITS)) begin
            next_r.bitCnt = 4'h0;
            case (r.ph)
              PH_ADDR: begin
                if (r.shift[7:1] == DEV_ADDR) begin
                  next_r.rw     = r.shift[0];
                  next_r.st     = DS_ACK;
                  next_r.sdaLow = 1'b1;
                end else begin
                  next_r.st = DS_IDLE;
                end
              end
              PH_REG: begin
                next_r.ptr    = r.shift;
                next_r.st     = DS_ACK;
                next_r.sdaLow = 1'b1;
              end
              default: begin
                next_r.regs[r.ptr[AW-1:0]] = r.shift;
                next_r.wrValid             = 1'b1;
                next_r.wrAddr              = r.ptr[AW-1:0];
                next_r.wrData              = r.shift;
                next_r.ptr                 = r.ptr + 8'h01;
                next_r.st                  = DS_ACK;
                next_r.sdaLow              = 1'b1;
              end
            endcase
          end
        end
        DS_ACK: begin
          // Released only at the fall that ends the acknowledge clock
          if (sclFall) begin
            next_r.sdaLow = 1'b0;
            if (r.ph == PH_ADDR && r.rw == RW_READ) begin
              loadTx = 1'b1;
            end else begin
              next_r.st = DS_RX;
              next_r.ph = (r.ph == PH_ADDR) ? PH_REG : PH_DATA;
            end
          end
        end
        DS_TX: begin
          if (sclFall) begin
            if (r.bitCnt == 4'(BYTE_BITS - 1)) begin
              next_r.sdaLow = 1'b0;
              next_r.st     = DS_MACK;
            end else begin
              next_r.shift  = {r.shift[6:0], 1'b0};
              next_r.sdaLow = ~r.shift[6];
              next_r.bitCnt = r.bitCnt + 4'h1;
            end
          end
        end
        DS_MACK: begin
          if (sclRise) begin
            next_r.mAck = ~r.sdaB;
          end else if (sclFall) begin
            if (r.mAck) begin
              loadTx = 1'b1;
            end else begin
              next_r.st = DS_IDLE;
            end
          end
        end
        default: begin
          next_r.sdaLow = 1'b0;
        end
      endcase
    end
    // Transmit start: MSB driven just after the clock fell
    if (loadTx) begin
      next_r.shift  = r.regs[r.ptr[AW-1:0]];
      next_r.sdaLow = ~r.regs[r.ptr[AW-1:0]][7];
      next_r.ptr    = r.ptr + 8'h01;
      next_r.bitCnt = 4'h0;
      next_r.st     = DS_TX;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= RST_STATE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: output level fixed low, enable low while pulling
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe  = ~r.sdaLow;
  assign regFlat        = r.regs;
  assign wrValid        = r.wrValid;
  assign wrAddr         = r.wrAddr;
  assign wrData         = r.wrData;
  assign busy           = (r.st != DS_IDLE);

endmodule
`default_nettype wire

/* File: bench/i2cr_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cr_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link drivers
  input wire logic hostSclOut,
  input wire logic hostSclOe,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  // Resolved lines
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic       prevScl;
  logic       prevSda;
  logic [3:0] riseCnt;

  // ------------------------------------------------------------
  // Clock counter
  // ------------------------------------------------------------
  // Nine clocks per byte; the rise that opens a stop makes it 1
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prevScl <= 1'b1;
      prevSda <= 1'b1;
      riseCnt <= 4'h1;
    end else begin
      prevScl <= scl;
      prevSda <= sda;
      if (scl && prevScl && prevSda && !sda) begin
        riseCnt <= 4'h0;
      end else if (scl && !prevScl) begin
        riseCnt <= (riseCnt == 4'h8) ? 4'h0 : riseCnt + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence startSeq;
    scl && $fell(sda);
  endsequence
  sequence stopSeq;
    scl && $rose(sda);
  endsequence

  a_lines_low_only: assert property (!hostSclOut && !hostSdaOut && !devSdaOut)
    else $error("a line driver drives high");
  a_dev_edge_low: assert property ($changed(devSdaOe) |-> !scl)
    else $error("device changed data while clock high");
  a_dev_bit_hold: assert property ($rose(scl) |=> $stable(devSdaOe) [*6])
    else $error("device data moved during clock high");
  a_ack_whole_clock: assert property ($rose(scl) && !devSdaOe |=> !devSdaOe [*6])
    else $error("device released low level early");
  a_host_bit_hold: assert property ($rose(scl) |-> $stable(hostSdaOe) [*3])
    else $error("host data moved during clock high");
  a_start_then_low: assert property (startSeq |-> ##[1:6] !scl)
    else $error("clock not lowered after start");
  a_stop_idle: assert property (stopSeq |=> scl [*8])
    else $error("clock pulled after stop");
  a_nine_bit_frame: assert property (stopSeq |-> riseCnt == 4'h1)
    else $error("frame not whole bytes of nine clocks");
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import i2cr_pkg::*;
  logic                   mclk      = 1'b0;
  logic                   rst       = 1'b1;
  logic                   loadValid = 1'b0;
  logic [4:0]             loadAddr  = 5'h00;
  logic [7:0]             loadData  = 8'h00;
  logic                   cmdValid  = 1'b0;
  logic                   cmdRead   = 1'b0;
  logic [6:0]             cmdAddr   = 7'h00;
  logic [7:0]             cmdReg    = 8'h00;
  logic [7:0]             cmdLen    = 8'h00;
  logic                   wdValid   = 1'b0;
  logic [7:0]             wdData    = 8'h00;
  logic [REG_COUNT*8-1:0] regFlat;
  logic                   wrValid, busy, cmdReady, wdReady, rdValid, done, nack;
  logic [4:0]             wrAddr;
  logic [7:0]             wrData, rdData;
  logic [7:0]             regModel [32];
  logic [7:0]             wq [$];
  int                     mismatches = 0;
  int                     checks = 0;
  int                     seed = 16789;
  int                     wrCount = 0;
  int                     expWr = 0;

  i2cr_if link ();
  i2cr_device u_i2cr_device (.mclk(mclk), .rst(rst), .link(link.dev), .loadValid(loadValid),
    .loadAddr(loadAddr), .loadData(loadData), .regFlat(regFlat), .wrValid(wrValid),
    .wrAddr(wrAddr), .wrData(wrData), .busy(busy));
  // Short quarter keeps each bit at 16 cycles, twice what the device needs
  i2cr_host #(.QCYC(4)) u_i2cr_host (.mclk(mclk), .rst(rst), .link(link.host),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdAddr(cmdAddr),
    .cmdReg(cmdReg), .cmdLen(cmdLen), .wdValid(wdValid), .wdReady(wdReady), .wdData(wdData),
    .rdValid(rdValid), .rdData(rdData), .done(done), .nack(nack));
  i2cr_monitor u_i2cr_monitor (.mclk(mclk), .rst(rst), .hostSclOut(link.hostSclOut),
    .hostSclOe(link.hostSclOe), .hostSdaOut(link.hostSdaOut), .hostSdaOe(link.hostSdaOe),
    .devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe), .scl(link.scl), .sda(link.sda));

  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    if (wrValid === 1'b1) begin
      wrCount <= wrCount + 1;
    end
  end

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic hang();
    cmpBit(1'b0, 1'b1);
    finish_test();
  endtask

  task automatic checkRegs();
    for (int k = 0; k < 32; k++) begin
      cmpByte(regFlat[8*k +: 8], regModel[k]);
    end
  endtask

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  // A gap of zero streams bytes with valid held high throughout
  task automatic pushBytes(input int cnt, input int gap);
    int n;
    for (int i = 0; i < cnt; i++) begin
      repeat (gap) @(negedge mclk);
      wdData = 8'($random(seed));
      wdValid = 1'b1;
      n = 0;
      while (wdReady !== 1'b1) begin
        @(negedge mclk);
        n++;
        if (n > 5000) hang();
      end
      wq.push_back(wdData);
      @(negedge mclk);
      if (gap > 0 || i == cnt - 1) wdValid = 1'b0;
    end
  endtask

  task automatic run(input logic rd, input logic [6:0] addr, input logic [7:0] ptr,
                     input logic [7:0] len);
    int n;
    int k;
    n = 0;
    k = 0;
    cmdValid = 1'b1;
    cmdRead = rd;
    cmdAddr = addr;
    cmdReg = ptr;
    cmdLen = len;
    if (cmdReady !== 1'b1) hang();
    @(negedge mclk);
    cmdValid = 1'b0;
    while (done !== 1'b1) begin
      if (rdValid === 1'b1) begin
        cmpByte(rdData, regModel[(ptr + k) % 32]);
        cmpBit(busy, 1'b1);
        k++;
      end
      @(negedge mclk);
      n++;
      if (n > 20000) hang();
    end
    cmpBit(busy, 1'b0);
    if (rd) begin
      cmpByte(8'(k), (addr == DEV_ADDR) ? len : 8'h00);
    end else begin
      for (int i = 0; i < len; i++) regModel[(ptr + i) % 32] = wq.pop_front();
      expWr += len;
    end
    cmpBit(nack, addr != DEV_ADDR);
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    loadValid = 1'b1;
    for (int k = 0; k < 32; k++) begin
      loadAddr = 5'(k);
      loadData = 8'($random(seed));
      regModel[k] = loadData;
      @(negedge mclk);
    end
    loadValid = 1'b0;
    @(negedge mclk);
    checkRegs();
    $display("test 1 done");
    // Pointer wraps past the top; late data makes the host stall the clock
    fork
      run(1'b0, DEV_ADDR, 8'hFE, 8'h04);
      pushBytes(4, 300);
    join
    checkRegs();
    cmpByte(wrData, regModel[1]);
    cmpByte(8'(wrAddr), 8'h01);
    $display("test 2 done");
    pushBytes(8, 0);
    cmpBit(wdReady, 1'b0);
    run(1'b0, DEV_ADDR, 8'h0A, 8'h08);
    pushBytes(1, 0);
    run(1'b0, DEV_ADDR, 8'h05, 8'h01);
    checkRegs();
    cmpByte(8'(wrCount), 8'(expWr));
    $display("test 3 done");
    run(1'b1, DEV_ADDR, 8'hFE, 8'h05);
    run(1'b1, DEV_ADDR, 8'h0B, 8'h01);
    $display("test 4 done");
    for (int i = 0; i < 3; i++) begin
      run(1'b1, DEV_ADDR ^ (7'h01 << (3 * i)), 8'h00, 8'h01);
    end
    checkRegs();
    run(1'b1, DEV_ADDR, 8'h00, 8'h02);
    $display("test 5 done");
    finish_test();
  end
endmodule
`default_nettype wire
